// *** cssg_defs.svh ***
// register offsets, field positions, reset values and fixed ratios of the clock controller
`ifndef CSSG_DEFS_SVH
`define CSSG_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CSSG_OFF_CTRL 12'h000
`define CSSG_OFF_SEL 12'h004
`define CSSG_OFF_STATUS 12'h008
`define CSSG_OFF_FLAG 12'h00c
`define CSSG_OFF_IEN 12'h010
`define CSSG_OFF_RUNEN 12'h014
`define CSSG_OFF_SLPEN 12'h018
`define CSSG_OFF_ACTSEL 12'h01c

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CSSG_DRIVE_LSB 0
`define CSSG_DRIVE_MSB 1
`define CSSG_BYPASS_BIT 2
`define CSSG_CSSEN_BIT 3

// ----------------------------------------------------------------
// selector slots: each takes three bits at three times its index
// ----------------------------------------------------------------
`define CSSG_MUX_SYS 0
`define CSSG_MUX_PLLREF 1
`define CSSG_MUX_USART 2
`define CSSG_MUX_I2C 3
`define CSSG_MUX_CEC 4
`define CSSG_MUX_RTC 5
`define CSSG_MUX_LPTIM 6
`define CSSG_MUX_SAI 7
`define CSSG_MUX_DSI 8
`define CSSG_MUX_MCO 9
`define CSSG_NMUX 10
`define CSSG_SEL_RESET 30'h00000000

// ----------------------------------------------------------------
// ready vector positions (status, flags and enables share them)
// ----------------------------------------------------------------
`define CSSG_RDY_PLL 0
`define CSSG_RDY_SERPLL 1
`define CSSG_RDY_DISPLL 2
`define CSSG_RDY_FEXT 3
`define CSSG_RDY_FINT 4
`define CSSG_RDY_SEXT 5
`define CSSG_RDY_SINT 6
`define CSSG_RDY_DSIPLL 7
`define CSSG_NRDY 7
`define CSSG_FLAG_CSS 7
`define CSSG_STAT_FAIL 8
`define CSSG_STAT_SYS_LSB 9

// ----------------------------------------------------------------
// peripheral enables
// ----------------------------------------------------------------
`define CSSG_PER_DTCM 0
`define CSSG_PER_RTC 1
`define CSSG_PER_USB 2
`define CSSG_PER_ETH 3
`define CSSG_RUNEN_RESET 32'h00000003
`define CSSG_SLPEN_RESET 32'hffffffff

// ----------------------------------------------------------------
// fixed source ratios
// ----------------------------------------------------------------
`define CSSG_CEC_FINT_DIV 9'h1e8
`define CSSG_RTC_FEXT_DIV 6'h20
`define CSSG_FINT_CODE 3'h0

`endif

// *** cssg_pkg.sv ***
// types shared by the clock selection and gating block
package cssg_pkg;
   // a source selector code, three bits wide for every multiplexer
   typedef logic [2:0] cssg_sel_t;
   // drive strength of the slow external oscillator, lowest power first
   typedef enum logic [1:0] {
      CSSG_DRIVE_LOW,
      CSSG_DRIVE_MEDLOW,
      CSSG_DRIVE_MEDHIGH,
      CSSG_DRIVE_HIGH
   } cssg_drive_t;
endpackage : cssg_pkg

// *** cssg_sync.sv ***
// two-flop synchroniser for a vector of independent levels
module cssg_sync #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // levels in and out
   input wire logic [W-1:0] asyncIn,
   output logic [W-1:0] syncOut
);
   // first stage, read only by the second stage
   logic [W-1:0] stage1;

   // ----------------------------------------------------------------
   // capture chain
   // ----------------------------------------------------------------
   // each bit is its own level; no bundle coherence is promised
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stage1 <= '0;
         syncOut <= '0;
      end else begin
         stage1 <= asyncIn;
         syncOut <= stage1;
      end
   end
endmodule : cssg_sync

// *** cssg_switch.sv ***
// glitch-free source selector: follows a request only once the new source is ready
module cssg_switch
   import cssg_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // request side
   input wire cssg_sel_t reqSel,
   input wire logic [7:0] srcReady,
   input wire logic forceNow,
   input wire cssg_sel_t forceSel,
   // active selection
   output cssg_sel_t actSel
);
   // ----------------------------------------------------------------
   // selection register
   // ----------------------------------------------------------------
   // a forced change (backup or wakeup) beats any pending request
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         actSel <= 3'h0;
      end else if (forceNow) begin
         actSel <= forceSel;
      end else if (reqSel != actSel && srcReady[reqSel]) begin
         actSel <= reqSel;
      end
   end
endmodule : cssg_switch

// *** cssg_top.sv ***
// clock source selection, peripheral gating and ready flags with an AHB-Lite register port
`include "cssg_defs.svh"

// Summary of operation
// - system clock from fast internal, external, PLL
// - three PLLs, reference internal or external
// - four slow crystal drives, changeable while running
// - slow oscillator bypass for external clock
// - serial port kernel clock: four sources
// - two-wire bus kernel clock: three sources
// - cec clock: slow external or internal/488
// - calendar: slow ext, slow int, ext/32
// - watchdog always on slow internal oscillator
// - low-power timer clock: five sources
// - usb and ethernet clocks from external PHY
// - audio clocks from PLLs, pin or oscillator
// - display host clock: PLL, system, own PLL
// - clock output pin picks one of six
// - peripheral clocks gateable; memories always clocked
// - run enables reset cleared except data RAM, calendar
// - disabled peripheral registers are not accessed
// - sleep enable acts only when run enabled
// - ready flags for oscillators and PLL locks except the DSI PLL
// - external oscillator failure breaks advanced timers
// - failure forces internal oscillator, raises NMI
// - Stop wakeup selects fast internal oscillator
module cssg_top
   import cssg_pkg::*;
#(
   parameter int NPERIPH = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // oscillator and PLL status pins, asynchronous
   input wire logic mainPllLock,
   input wire logic audioSerialPllLock,
   input wire logic audioDisplayPllLock,
   input wire logic fastExternalOscReady,
   input wire logic fastInternalOscReady,
   input wire logic slowExternalOscReady,
   input wire logic slowInternalOscReady,
   input wire logic dsiPllLock,
   input wire logic fastExternalOscFail,
   // power mode, from the core clock domain
   input wire logic sleepMode,
   input wire logic stopWake,
   // active source selections
   output cssg_sel_t sysClkSel,
   output cssg_sel_t pllRefSel,
   output cssg_sel_t usartClkSel,
   output cssg_sel_t i2cClkSel,
   output cssg_sel_t cecClkSel,
   output cssg_sel_t rtcClkSel,
   output cssg_sel_t lptimClkSel,
   output cssg_sel_t saiClkSel,
   output cssg_sel_t dsiClkSel,
   output cssg_sel_t mcoSel,
   // fixed ratios and watchdog source
   output logic [8:0] cecFintDiv,
   output logic [5:0] rtcFextDiv,
   output logic watchdogClkOn,
   // slow external oscillator setup
   output cssg_drive_t slowExtDrive,
   output logic slowExtBypass,
   // gating
   output logic [NPERIPH-1:0] periphClkOn,
   output logic [NPERIPH-1:0] periphRegAccessEn,
   output logic [1:0] extPhyClkOn,
   output logic memClkOn,
   // safety and ready events
   output logic timerBreak,
   output logic cssNmi,
   output logic readyIrq
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [1:0] driveReg; // slow crystal drive
   logic bypassReg; // slow oscillator bypass
   logic cssEnReg; // clock security enable
   logic [`CSSG_NMUX*3-1:0] selReg; // requested selections
   logic [`CSSG_NMUX*3-1:0] actVec; // active selections
   logic [NPERIPH-1:0] runEn; // run-mode enables
   logic [NPERIPH-1:0] slpEn; // sleep-mode enables
   logic [7:0] rdyFlag; // sticky ready and failure flags
   logic [7:0] irqEn; // flag enables
   logic [7:0] rdySync; // synchronised ready levels
   logic [7:0] rdyPrev; // previous ready levels
   logic failSync; // synchronised failure level
   logic failPrev; // previous failure level
   logic failRise; // failure onset this cycle
   logic forceSys; // forced return to internal oscillator
   logic [7:0] muxRdy [`CSSG_NMUX]; // ready map per multiplexer
   // bus
   logic addrTaken; // address phase accepted
   logic wrPend; // write data phase
   logic rdWait; // read wait state
   logic [11:0] wrAddr; // latched write offset
   logic [11:0] rdAddr; // latched read offset
   logic afterRst; // helper for checks

   // ----------------------------------------------------------------
   // synchronisers
   // ----------------------------------------------------------------
   cssg_sync #(.W(8)) u_rdySync (
      .clk(clk),
      .nrst(nrst),
      .asyncIn({dsiPllLock, slowInternalOscReady, slowExternalOscReady, fastInternalOscReady,
                fastExternalOscReady, audioDisplayPllLock, audioSerialPllLock, mainPllLock}),
      .syncOut(rdySync)
   );

   cssg_sync #(.W(1)) u_failSync (
      .clk(clk),
      .nrst(nrst),
      .asyncIn(fastExternalOscFail),
      .syncOut(failSync)
   );

   // edge history of the synchronised levels
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdyPrev <= 8'h00;
         failPrev <= 1'b0;
      end else begin
         rdyPrev <= rdySync;
         failPrev <= failSync;
      end
   end

   assign failRise = failSync & ~failPrev;

   // ----------------------------------------------------------------
   // source ready maps, one slot per selector code
   // ----------------------------------------------------------------
   // internal, external, main PLL
   assign muxRdy[`CSSG_MUX_SYS] = {5'h00, rdySync[`CSSG_RDY_PLL], rdySync[`CSSG_RDY_FEXT],
                                   rdySync[`CSSG_RDY_FINT]};
   assign muxRdy[`CSSG_MUX_PLLREF] = {6'h00, rdySync[`CSSG_RDY_FEXT], rdySync[`CSSG_RDY_FINT]};
   // system, fast int, slow ext, bus clock
   assign muxRdy[`CSSG_MUX_USART] = {4'h0, 1'b1, rdySync[`CSSG_RDY_SEXT],
                                     rdySync[`CSSG_RDY_FINT], 1'b1};
   // system, fast int, slow bus clock
   assign muxRdy[`CSSG_MUX_I2C] = {5'h00, 1'b1, rdySync[`CSSG_RDY_FINT], 1'b1};
   assign muxRdy[`CSSG_MUX_CEC] = {6'h00, rdySync[`CSSG_RDY_FINT], rdySync[`CSSG_RDY_SEXT]};
   // slow ext, slow int, divided fast ext
   assign muxRdy[`CSSG_MUX_RTC] = {5'h00, rdySync[`CSSG_RDY_FEXT], rdySync[`CSSG_RDY_SINT],
                                   rdySync[`CSSG_RDY_SEXT]};
   // slow int, slow ext, fast int, bus, pin
   assign muxRdy[`CSSG_MUX_LPTIM] = {3'h0, 1'b1, 1'b1, rdySync[`CSSG_RDY_FINT],
                                     rdySync[`CSSG_RDY_SEXT], rdySync[`CSSG_RDY_SINT]};
   // serial PLL, display PLL, pin, fast int
   assign muxRdy[`CSSG_MUX_SAI] = {4'h0, rdySync[`CSSG_RDY_FINT], 1'b1,
                                   rdySync[`CSSG_RDY_DISPLL], rdySync[`CSSG_RDY_SERPLL]};
   // main PLL, system clock, own PLL
   assign muxRdy[`CSSG_MUX_DSI] = {5'h00, rdySync[`CSSG_RDY_DSIPLL], 1'b1,
                                   rdySync[`CSSG_RDY_PLL]};
   // six output choices; codes six and seven never become ready
   assign muxRdy[`CSSG_MUX_MCO] = {2'h0, rdySync[`CSSG_RDY_SERPLL], rdySync[`CSSG_RDY_PLL], 1'b1,
                                   rdySync[`CSSG_RDY_SEXT], rdySync[`CSSG_RDY_FEXT],
                                   rdySync[`CSSG_RDY_FINT]};

   // ----------------------------------------------------------------
   // selectors
   // ----------------------------------------------------------------
   // failure or wakeup forces the system clock
   assign forceSys = stopWake | (failRise & cssEnReg);

   genvar g;
   generate
      for (g = 0; g < `CSSG_NMUX; g++) begin : gen_mux
         cssg_switch u_sw (
            .clk(clk),
            .nrst(nrst),
            .reqSel(selReg[3*g +: 3]),
            .srcReady(muxRdy[g]),
            .forceNow((g == `CSSG_MUX_SYS) ? forceSys : 1'b0),
            .forceSel(`CSSG_FINT_CODE),
            .actSel(actVec[3*g +: 3])
         );
      end
   endgenerate

   assign sysClkSel = actVec[3*`CSSG_MUX_SYS +: 3];
   assign pllRefSel = actVec[3*`CSSG_MUX_PLLREF +: 3];
   assign usartClkSel = actVec[3*`CSSG_MUX_USART +: 3];
   assign i2cClkSel = actVec[3*`CSSG_MUX_I2C +: 3];
   assign cecClkSel = actVec[3*`CSSG_MUX_CEC +: 3];
   assign rtcClkSel = actVec[3*`CSSG_MUX_RTC +: 3];
   assign lptimClkSel = actVec[3*`CSSG_MUX_LPTIM +: 3];
   assign saiClkSel = actVec[3*`CSSG_MUX_SAI +: 3];
   assign dsiClkSel = actVec[3*`CSSG_MUX_DSI +: 3];
   assign mcoSel = actVec[3*`CSSG_MUX_MCO +: 3];

   // ----------------------------------------------------------------
   // fixed sources
   // ----------------------------------------------------------------
   // internal oscillator ratio for the cec clock
   assign cecFintDiv = `CSSG_CEC_FINT_DIV;
   // external oscillator ratio for the calendar
   assign rtcFextDiv = `CSSG_RTC_FEXT_DIV;
   // watchdog runs whenever the slow internal oscillator does
   assign watchdogClkOn = rdySync[`CSSG_RDY_SINT];
   // drive goes straight out, so it may change at any time
   assign slowExtDrive = cssg_drive_t'(driveReg);
   // bypass lets a driven clock replace the crystal
   assign slowExtBypass = bypassReg;

   // ----------------------------------------------------------------
   // gating
   // ----------------------------------------------------------------
   // run enable, and sleep enable only under a run enable
   assign periphClkOn = runEn & (sleepMode ? slpEn : {NPERIPH{1'b1}});
   // bus access to a peripheral only while its run enable is set
   assign periphRegAccessEn = runEn;
   // PHY-supplied clocks are gated here but never multiplexed
   assign extPhyClkOn = periphClkOn[`CSSG_PER_ETH:`CSSG_PER_USB];
   // memories stay clocked in run and sleep
   assign memClkOn = 1'b1;

   // ----------------------------------------------------------------
   // ready flags and clock security
   // ----------------------------------------------------------------
   // a set in the clearing cycle wins, so no lock event is lost
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdyFlag <= 8'h00;
      end else begin
         // flag each ready rise except the DSI PLL lock; failure flag
         rdyFlag <= (rdyFlag & ~((wrPend && wrAddr == `CSSG_OFF_FLAG) ? hwdata[7:0] : 8'h00))
                    | {failRise & cssEnReg, rdySync[6:0] & ~rdyPrev[6:0]};
      end
   end

   // one-cycle break to the advanced timers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         timerBreak <= 1'b0;
      end else begin
         timerBreak <= failRise & cssEnReg;
      end
   end

   // the NMI stays up until software clears the failure flag
   assign cssNmi = rdyFlag[`CSSG_FLAG_CSS];
   assign readyIrq = |(rdyFlag[6:0] & irqEn[6:0]);

   // ----------------------------------------------------------------
   // AHB-Lite slave
   // ----------------------------------------------------------------
   // only whole-word single transfers are expected, so hsize is not decoded
   assign addrTaken = hsel & htrans[1] & hready;
   assign hreadyout = ~rdWait;
   assign hresp = 1'b0;

   // phase tracking; reads take one wait state so a preceding write lands first
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wrPend <= 1'b0;
         rdWait <= 1'b0;
         wrAddr <= 12'h000;
         rdAddr <= 12'h000;
      end else begin
         wrPend <= addrTaken & hwrite;
         rdWait <= addrTaken & ~hwrite;
         if (addrTaken) begin
            wrAddr <= haddr[11:0];
            rdAddr <= haddr[11:0];
         end
      end
   end

   // read decode; unmapped offsets read as zero
   function automatic logic [31:0] readWord(input logic [11:0] a);
      logic [31:0] d;
      d = 32'h00000000;
      if (a == `CSSG_OFF_CTRL) begin
         d[3:0] = {cssEnReg, bypassReg, driveReg};
      end else if (a == `CSSG_OFF_SEL) begin
         d[29:0] = selReg;
      end else if (a == `CSSG_OFF_STATUS) begin
         d[11:0] = {sysClkSel, failSync, rdySync};
      end else if (a == `CSSG_OFF_FLAG) begin
         d[7:0] = rdyFlag;
      end else if (a == `CSSG_OFF_IEN) begin
         d[7:0] = irqEn;
      end else if (a == `CSSG_OFF_RUNEN) begin
         d[NPERIPH-1:0] = runEn;
      end else if (a == `CSSG_OFF_SLPEN) begin
         d[NPERIPH-1:0] = slpEn;
      end else if (a == `CSSG_OFF_ACTSEL) begin
         d[29:0] = actVec;
      end
      return d;
   endfunction : readWord

   // read data is taken during the wait state
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hrdata <= 32'h00000000;
      end else if (rdWait) begin
         hrdata <= readWord(rdAddr);
      end
   end

   // software-written control state
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         driveReg <= 2'h0;
         bypassReg <= 1'b0;
         cssEnReg <= 1'b0;
         selReg <= `CSSG_SEL_RESET;
         irqEn <= 8'h00;
      end else if (wrPend) begin
         if (wrAddr == `CSSG_OFF_CTRL) begin
            driveReg <= hwdata[`CSSG_DRIVE_MSB:`CSSG_DRIVE_LSB];
            bypassReg <= hwdata[`CSSG_BYPASS_BIT];
            cssEnReg <= hwdata[`CSSG_CSSEN_BIT];
         end else if (wrAddr == `CSSG_OFF_SEL) begin
            selReg <= hwdata[29:0];
         end else if (wrAddr == `CSSG_OFF_IEN) begin
            irqEn <= hwdata[7:0];
         end
      end
   end

   // peripheral enables
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         // data RAM and calendar start enabled
         runEn <= NPERIPH'(`CSSG_RUNEN_RESET);
         slpEn <= NPERIPH'(`CSSG_SLPEN_RESET);
      end else if (wrPend) begin
         if (wrAddr == `CSSG_OFF_RUNEN) begin
            runEn <= hwdata[NPERIPH-1:0];
         end else if (wrAddr == `CSSG_OFF_SLPEN) begin
            slpEn <= hwdata[NPERIPH-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // marks the first cycle after reset release
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         afterRst <= 1'b0;
      end else begin
         afterRst <= 1'b1;
      end
   end

   chk_wake_fint: assert property (@(posedge clk) disable iff (!nrst)
      stopWake |=> sysClkSel == `CSSG_FINT_CODE)
      else $error("system clock not internal after wakeup");

   chk_css_backup: assert property (@(posedge clk) disable iff (!nrst)
      (failRise && cssEnReg) |=> (sysClkSel == `CSSG_FINT_CODE) && cssNmi)
      else $error("no backup clock or nmi after failure");

   chk_break_pulse: assert property (@(posedge clk) disable iff (!nrst)
      $rose(failSync) && cssEnReg |=> timerBreak ##1 !timerBreak)
      else $error("break pulse wrong after failure");

   chk_sleep_gate: assert property (@(posedge clk) disable iff (!nrst)
      (sleepMode && !slpEn[`CSSG_PER_USB]) || !runEn[`CSSG_PER_USB] |-> !periphClkOn[`CSSG_PER_USB])
      else $error("peripheral clock runs while gated");

   chk_enable_reset: assert property (@(posedge clk) disable iff (!nrst)
      !afterRst |-> runEn == NPERIPH'(`CSSG_RUNEN_RESET))
      else $error("run enables wrong after reset");

   chk_lock_flag: assert property (@(posedge clk) disable iff (!nrst)
      $rose(rdySync[`CSSG_RDY_PLL]) |=> rdyFlag[`CSSG_RDY_PLL])
      else $error("lock flag not set");

   chk_switch_wait: assert property (@(posedge clk) disable iff (!nrst)
      (selReg[2:0] != sysClkSel && !muxRdy[0][selReg[2:0]] && !forceSys) |=> $stable(sysClkSel))
      else $error("system clock switched to a source not ready");

   chk_mco_range: assert property (@(posedge clk) disable iff (!nrst)
      mcoSel < 3'h6)
      else $error("clock output on an undefined source");
endmodule : cssg_top

// *** cssg_osc_model.sv ***
// behavioural oscillators and PLLs facing the clock selection block
module cssg_osc_model #(
   parameter int LAT = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // commands from the bench
   input wire logic [7:0] oscOn,
   input wire logic failCmd,
   // status pins towards the block
   output logic [7:0] ready,
   output logic fail
);
   // ----------------------------------------------------------------
   // start-up delay
   // ----------------------------------------------------------------
   logic [LAT-1:0][7:0] pipe; // ready levels on their way out
   // a source reports ready only some cycles after it is switched on
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pipe <= '0;
      end else begin
         pipe <= {pipe[LAT-2:0], oscOn};
      end
   end
   // a failed crystal drops its ready at once, it is no kinder than silicon
   assign ready = pipe[LAT-1] & ~{4'h0, failCmd, 3'h0};
   assign fail = failCmd;
endmodule : cssg_osc_model

// *** tb_top.sv ***
// self-checking bench for the clock selection and gating block
`include "cssg_defs.svh"
module tb_top
   import cssg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // stimulus and observed signals
   // ----------------------------------------------------------------
   logic clk = 1'b0, nrst = 1'b0, hsel = 1'b1, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2; // whole words only
   logic [7:0] oscOn = 8'h78; // oscillators on, PLLs off
   logic failCmd = 1'b0, sleepMode = 1'b0, stopWake = 1'b0;
   wire logic hreadyout, hresp, slowExtBypass, memClkOn, timerBreak, cssNmi, readyIrq;
   wire logic watchdogClkOn, fextFail;
   wire logic [31:0] hrdata, periphClkOn, periphRegAccessEn;
   wire logic [7:0] rdy;
   wire logic [8:0] cecFintDiv;
   wire logic [5:0] rtcFextDiv;
   wire logic [1:0] extPhyClkOn;
   wire cssg_sel_t sysClkSel;
   wire cssg_drive_t slowExtDrive;
   int mismatches = 0, checks_done = 0, breaks = 0;
   always #50 clk = ~clk;
   // break pulses are counted off-edge so the count never races the register
   always @(negedge clk) if (timerBreak === 1'b1) breaks++;
   cssg_osc_model cssg_osc_model_inst (.clk(clk), .nrst(nrst), .oscOn(oscOn),
      .failCmd(failCmd), .ready(rdy), .fail(fextFail));
   cssg_top cssg_top_inst (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .mainPllLock(rdy[0]),
      .audioSerialPllLock(rdy[1]), .audioDisplayPllLock(rdy[2]), .fastExternalOscReady(rdy[3]),
      .fastInternalOscReady(rdy[4]), .slowExternalOscReady(rdy[5]),
      .slowInternalOscReady(rdy[6]), .dsiPllLock(rdy[7]), .fastExternalOscFail(fextFail),
      .sleepMode(sleepMode), .stopWake(stopWake), .sysClkSel(sysClkSel), .pllRefSel(),
      .usartClkSel(), .i2cClkSel(), .cecClkSel(), .rtcClkSel(), .lptimClkSel(), .saiClkSel(),
      .dsiClkSel(), .mcoSel(), .cecFintDiv(cecFintDiv), .rtcFextDiv(rtcFextDiv),
      .watchdogClkOn(watchdogClkOn), .slowExtDrive(slowExtDrive), .slowExtBypass(slowExtBypass),
      .periphClkOn(periphClkOn), .periphRegAccessEn(periphRegAccessEn),
      .extPhyClkOn(extPhyClkOn), .memClkOn(memClkOn), .timerBreak(timerBreak), .cssNmi(cssNmi),
      .readyIrq(readyIrq));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // wait for hready high at a falling edge; read data is taken there
   task automatic answer();
      @(negedge clk);
      while (hreadyout !== 1'b1) @(negedge clk);
      rd = hrdata;
      @(posedge clk);
   endtask : answer
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      htrans <= 2'h2;
      haddr <= {20'h0, a};
      hwrite <= wr;
      answer();
      htrans <= 2'h0;
      hwdata <= wr ? d : 32'h0;
      answer();
   endtask : bus
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic tally_and_finish();
      if (mismatches == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      cyc(12);
      bus(0, `CSSG_OFF_RUNEN, 0);
      chk(rd, `CSSG_RUNEN_RESET);
      chk(periphClkOn, 32'h3);
      chk(32'(memClkOn), 32'h1);
      chk(32'(watchdogClkOn), 32'h1);
      chk(32'(cecFintDiv), 32'h1e8);
      chk(32'(rtcFextDiv), 32'h20);
      bus(0, 12'h040, 0);
      chk(rd, 32'h0); // unmapped offset reads zero
      bus(0, `CSSG_OFF_FLAG, 0);
      chk(rd, 32'h78);
      chk(32'(readyIrq), 32'h0);
      bus(1, `CSSG_OFF_IEN, 32'h8);
      cyc(1);
      chk(32'(readyIrq), 32'h1);
      bus(1, `CSSG_OFF_FLAG, 32'h78);
      cyc(1);
      chk(32'(readyIrq), 32'h0);
      // switch only to a locked PLL
      // software keeps the PLL rate in range
      bus(1, `CSSG_OFF_SEL, 32'h2);
      cyc(10);
      chk(32'(sysClkSel), 32'h0);
      oscOn <= 8'h79;
      cyc(12);
      chk(32'(sysClkSel), 32'h2);
      // every drive setting, bypass toggled, security logic on
      for (int i = 0; i < 4; i++) begin
         bus(1, `CSSG_OFF_CTRL, {28'h0, 1'b1, 1'(i), 2'(i)});
         cyc(1);
         chk(32'(slowExtDrive), 32'(i));
         chk(32'(slowExtBypass), 32'(i & 1));
      end
      bus(1, `CSSG_OFF_RUNEN, 32'h5);
      bus(1, `CSSG_OFF_SLPEN, 32'h3);
      cyc(1);
      chk(periphClkOn, 32'h5);
      chk(32'(extPhyClkOn), 32'h1);
      chk(periphRegAccessEn, 32'h5);
      sleepMode <= 1'b1;
      cyc(1);
      chk(periphClkOn, 32'h1);
      sleepMode <= 1'b0;
      // crystal failure while running from it
      bus(1, `CSSG_OFF_SEL, 32'h1);
      cyc(3);
      chk(32'(sysClkSel), 32'h1);
      failCmd <= 1'b1;
      cyc(8);
      chk(32'(breaks), 32'h1);
      chk(32'(cssNmi), 32'h1);
      chk(32'(sysClkSel), 32'h0);
      failCmd <= 1'b0;
      bus(1, `CSSG_OFF_FLAG, 32'h80);
      cyc(1);
      chk(32'(cssNmi), 32'h0);
      // wakeup from stop forces the internal oscillator
      cyc(10);
      chk(32'(sysClkSel), 32'h1);
      @(posedge clk);
      stopWake <= 1'b1;
      @(posedge clk);
      stopWake <= 1'b0;
      @(negedge clk);
      chk(32'(sysClkSel), 32'h0);
      // ready sources follow, the unlocked serial PLL on the output pin does not
      cyc(1);
      bus(1, `CSSG_OFF_SEL, 32'h28001081);
      cyc(2);
      bus(0, `CSSG_OFF_ACTSEL, 0);
      chk(rd, 32'h00001081);
      chk(32'(hresp), 32'h0); // responses stay OKAY
      tally_and_finish();
   end
   // a hang ends the run as a failure
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      tally_and_finish();
   end
endmodule : tb_top
